// file: positioner_mode_pkg.sv
// constants, register map and types for the positioner operating-mode sequencer
// assumes a single 20 MHz clock domain and an APB master on the same clock

package positioner_mode_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] TIMEOUT_OFFSET = 8'h08;
  localparam logic [7:0] SETPOINT_OFFSET = 8'h0C;

  // ----------------------------------------------------------------
  // control fields (write-one pulses in bits 0..2, levels above)
  // ----------------------------------------------------------------
  localparam int CTRL_CAL_START_BIT = 0;
  localparam int CTRL_RESTORE_BIT = 1;
  localparam int CTRL_FAULT_ACK_BIT = 2;
  localparam int CTRL_SEL_ANALOG_BIT = 4;
  localparam int CTRL_FALLBACK_LSB = 8;

  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [31:0] TIMEOUT_RESET = 32'h0000_4E20;
  localparam logic [1:0] FALLBACK_RESET = 2'h0;
  localparam logic [3:0] TEST_STEPS = 4'h8;
  localparam logic [3:0] TEST_NONE = 4'h0;
  localparam logic [1:0] KEYS_ALL = 2'h3;
  localparam int SETPOINT_WIDTH = 16;

  // ----------------------------------------------------------------
  // timing: one self-test step lasts 1 ms
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int STEP_US = 1000;
  localparam int STEP_CYCLES = (CLK_HZ / 1_000_000) * STEP_US;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    MODE_INIT = 6'b00_0001,
    MODE_OUT_OF_SERVICE = 6'b00_0010,
    MODE_CALIBRATE = 6'b00_0100,
    MODE_OPERATE = 6'b00_1000,
    MODE_SETPOINT_LOSS = 6'b01_0000,
    MODE_FAULT = 6'b10_0000
  } mode_type;

  typedef enum logic [1:0] {
    FALLBACK_HOLD = 2'h0,
    FALLBACK_VENT = 2'h1,
    FALLBACK_PRESET = 2'h2
  } fallback_type;

  typedef struct packed {
    logic red;
    logic [3:0] green;
  } lamps_type;

  typedef struct packed {
    logic valid;
    logic [SETPOINT_WIDTH-1:0] value;
  } setpoint_type;

endpackage

// file: positioner_mode_sequencer.sv
// operating-mode sequencer of the positioner with its APB register file
// assumes keys, test results and link/analog samples are synchronous except the key pins
`timescale 1ns/1ps

module positioner_mode_sequencer #(
  parameter int STEP_COUNT = positioner_mode_pkg::STEP_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // local keys (pins, asynchronous)
  input wire logic keyUp,
  input wire logic keyDown,
  input wire logic keyMenu,
  // self-test and calibration engines
  input wire logic testFail,
  input wire logic cyclicFault,
  input wire logic calDone,
  input wire logic calNvIn,
  input wire logic calNvInValid,
  // setpoint sources
  input wire positioner_mode_pkg::setpoint_type linkSetpoint,
  input wire positioner_mode_pkg::setpoint_type adcSetpoint,
  // outputs
  output positioner_mode_pkg::mode_type mode,
  output positioner_mode_pkg::lamps_type lamps,
  output logic [3:0] testCode,
  output logic menuEnable,
  output logic calStroke,
  output logic calNvOut,
  output logic diagRun,
  output positioner_mode_pkg::setpoint_type ctrlSetpoint,
  output logic [1:0] fallbackAct
);
  import positioner_mode_pkg::*;

  if (STEP_COUNT < 1) begin : g_step_check
    $error("STEP_COUNT must be at least one");
  end

  // ----------------------------------------------------------------
  // key synchronisers
  // ----------------------------------------------------------------
  logic [2:0] keyMeta_ff;
  logic [2:0] keySync_ff;
  logic keyResetSeen_ff;
  logic keyResetPulse;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      keyMeta_ff <= 3'h0;
      keySync_ff <= 3'h0;
    end else if (clkEn) begin
      keyMeta_ff <= {keyMenu, keyDown, keyUp};
      keySync_ff <= keyMeta_ff;
    end
  end

  // three keys pressed together give one reset pulse per press
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      keyResetSeen_ff <= 1'b0;
    end else if (clkEn) begin
      keyResetSeen_ff <= &keySync_ff;
    end
  end
  assign keyResetPulse = (&keySync_ff) && !keyResetSeen_ff;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] timeoutLimit_ff;
  logic [1:0] fallbackSel_ff;
  logic selAnalog_ff;
  logic calFlag_ff;
  logic calStartReq_ff;
  logic restoreReq_ff;
  logic faultAckReq_ff;
  logic wrAccess;
  logic rdAccess;
  logic addrOk;

  assign wrAccess = psel && penable && pwrite && pready;
  assign rdAccess = psel && !penable && !pwrite;
  assign addrOk = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET) ||
                  (paddr == TIMEOUT_OFFSET) || (paddr == SETPOINT_OFFSET);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      timeoutLimit_ff <= TIMEOUT_RESET;
      fallbackSel_ff <= FALLBACK_RESET;
      selAnalog_ff <= 1'b0;
    end else if (clkEn && wrAccess) begin
      if (paddr == TIMEOUT_OFFSET) begin
        for (int b = 0; b < 4; b++) begin
          if (pstrb[b]) begin
            timeoutLimit_ff[b*8 +: 8] <= pwdata[b*8 +: 8];
          end
        end
      end else if (paddr == CTRL_OFFSET) begin
        if (pstrb[0]) begin
          selAnalog_ff <= pwdata[CTRL_SEL_ANALOG_BIT];
        end
        if (pstrb[1]) begin
          fallbackSel_ff <= pwdata[CTRL_FALLBACK_LSB +: 2];
        end
      end
    end
  end

  // command pulses; calibration start and restore are consumed by the sequencer next cycle, fault acknowledge is unused
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      calStartReq_ff <= 1'b0;
      restoreReq_ff <= 1'b0;
      faultAckReq_ff <= 1'b0;
    end else if (clkEn) begin
      calStartReq_ff <= wrAccess && (paddr == CTRL_OFFSET) && pstrb[0] &&
                        pwdata[CTRL_CAL_START_BIT];
      restoreReq_ff <= wrAccess && (paddr == CTRL_OFFSET) && pstrb[0] &&
                       pwdata[CTRL_RESTORE_BIT];
      faultAckReq_ff <= wrAccess && (paddr == CTRL_OFFSET) && pstrb[0] &&
                        pwdata[CTRL_FAULT_ACK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // setpoint selector and loss timer
  // ----------------------------------------------------------------
  setpoint_type selSetpoint;
  logic [31:0] silence_ff;
  logic lossTimeout;

  assign selSetpoint = selAnalog_ff ? adcSetpoint : linkSetpoint;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      silence_ff <= 32'h0000_0000;
    end else if (clkEn) begin
      if (selSetpoint.valid || (mode != MODE_OPERATE)) begin
        silence_ff <= 32'h0000_0000;
      end else if (!lossTimeout) begin
        silence_ff <= silence_ff + 32'h0000_0001;
      end
    end
  end
  assign lossTimeout = (silence_ff >= timeoutLimit_ff);

  // ----------------------------------------------------------------
  // self-test stepping
  // ----------------------------------------------------------------
  logic [31:0] stepTimer_ff;
  logic [3:0] step_ff;
  logic testsDone;
  logic stepTick;

  assign stepTick = (stepTimer_ff == 32'(STEP_COUNT - 1));
  assign testsDone = (step_ff == TEST_STEPS);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stepTimer_ff <= 32'h0000_0000;
      step_ff <= TEST_NONE;
    end else if (clkEn) begin
      if (keyResetPulse) begin
        stepTimer_ff <= 32'h0000_0000;
        step_ff <= TEST_NONE;
      end else if (mode == MODE_INIT && !testsDone && !testFail) begin
        stepTimer_ff <= stepTick ? 32'h0000_0000 : stepTimer_ff + 32'h0000_0001;
        if (stepTick) begin
          step_ff <= step_ff + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // kept calibration flag
  // ----------------------------------------------------------------
  logic calLoaded_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      calFlag_ff <= 1'b0;
      calLoaded_ff <= 1'b0;
    end else if (clkEn) begin
      if (!calLoaded_ff && calNvInValid) begin
        calFlag_ff <= calNvIn;
        calLoaded_ff <= 1'b1;
      end else if (mode == MODE_CALIBRATE && calDone) begin
        calFlag_ff <= 1'b1;
      end else if (restoreReq_ff && mode != MODE_FAULT && mode != MODE_CALIBRATE) begin
        calFlag_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  mode_type mode_ff;
  mode_type nxt_mode;
  logic [3:0] failCode_ff;

  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_INIT: begin
        if (testFail) begin
          nxt_mode = MODE_INIT;
        end else if (testsDone && calLoaded_ff) begin
          nxt_mode = calFlag_ff ? MODE_OPERATE : MODE_OUT_OF_SERVICE;
        end
      end
      MODE_OUT_OF_SERVICE: begin
        if (cyclicFault) begin
          nxt_mode = MODE_FAULT;
        end else if (calStartReq_ff) begin
          nxt_mode = MODE_CALIBRATE;
        end
      end
      MODE_CALIBRATE: begin
        if (cyclicFault) begin
          nxt_mode = MODE_FAULT;
        end else if (calDone) begin
          nxt_mode = MODE_OPERATE;
        end
      end
      MODE_OPERATE: begin
        if (cyclicFault) begin
          nxt_mode = MODE_FAULT;
        end else if (restoreReq_ff) begin
          nxt_mode = MODE_OUT_OF_SERVICE;
        end else if (calStartReq_ff) begin
          nxt_mode = MODE_CALIBRATE;
        end else if (!selSetpoint.valid && lossTimeout) begin
          nxt_mode = MODE_SETPOINT_LOSS;
        end
      end
      MODE_SETPOINT_LOSS: begin
        if (cyclicFault) begin
          nxt_mode = MODE_FAULT;
        end else if (selSetpoint.valid) begin
          nxt_mode = MODE_OPERATE;
        end
      end
      MODE_FAULT: begin
        nxt_mode = MODE_FAULT;
      end
      default: begin
        nxt_mode = MODE_FAULT;
      end
    endcase
    if (keyResetPulse) begin
      nxt_mode = MODE_INIT;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= MODE_INIT;
    end else if (clkEn) begin
      mode_ff <= nxt_mode;
    end
  end

  // failing step code is frozen while initialization halts
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      failCode_ff <= TEST_NONE;
    end else if (clkEn) begin
      if (keyResetPulse) begin
        failCode_ff <= TEST_NONE;
      end else if (mode_ff == MODE_INIT && testFail && failCode_ff == TEST_NONE) begin
        failCode_ff <= step_ff + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      testCode <= TEST_NONE;
      menuEnable <= 1'b0;
      calStroke <= 1'b0;
      calNvOut <= 1'b0;
      diagRun <= 1'b0;
      fallbackAct <= FALLBACK_HOLD;
    end else if (clkEn) begin
      calNvOut <= calFlag_ff;
      calStroke <= (nxt_mode == MODE_CALIBRATE);
      menuEnable <= (nxt_mode != MODE_FAULT);
      diagRun <= (nxt_mode != MODE_INIT) && (nxt_mode != MODE_FAULT);
      testCode <= (failCode_ff != TEST_NONE) ? failCode_ff : step_ff;
      fallbackAct <= (nxt_mode == MODE_SETPOINT_LOSS) ? fallbackSel_ff : FALLBACK_HOLD;
    end
  end

  // controller setpoint: value holds, valid pulses once per accepted sample
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrlSetpoint <= '0;
    end else if (clkEn) begin
      if (nxt_mode == MODE_OPERATE && selSetpoint.valid) begin
        ctrlSetpoint <= selSetpoint;
      end else begin
        ctrlSetpoint.valid <= 1'b0;
      end
    end
  end

  // status lamps follow the mode being entered
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lamps <= '0;
    end else if (clkEn) begin
      if (nxt_mode == MODE_FAULT) begin
        lamps <= '{red: 1'b1, green: 4'h0};
      end else if (nxt_mode == MODE_INIT) begin
        lamps <= '{red: 1'b0, green: step_ff};
      end else begin
        lamps <= '{red: 1'b0, green: {2'h0, nxt_mode == MODE_OPERATE,
                                     nxt_mode == MODE_SETPOINT_LOSS}};
      end
    end
  end
  assign mode = mode_ff;

  // ----------------------------------------------------------------
  // apb read path: one-cycle answer, unmapped address errors
  // ----------------------------------------------------------------
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;
  logic [31:0] setpointWord;

  assign ctrlWord = {22'h00_0000, fallbackSel_ff, 3'h0, selAnalog_ff, 4'h0};
  assign statusWord = {20'h0_0000, failCode_ff, 1'b0, calFlag_ff, mode_ff};
  assign setpointWord = {15'h0000, ctrlSetpoint.valid, ctrlSetpoint.value};

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      if (rdAccess) begin
        unique case (paddr)
          CTRL_OFFSET: prdata <= ctrlWord;
          STATUS_OFFSET: prdata <= statusWord;
          TIMEOUT_OFFSET: prdata <= timeoutLimit_ff;
          SETPOINT_OFFSET: prdata <= setpointWord;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // positioner_mode_sequencer

// file: positioner_mode_properties.sv
// property checker for the positioner operating-mode sequencer
// assumes it is bound to the sequencer top: one clock, asynchronous low reset
`timescale 1ns/1ps
module positioner_mode_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // watched ports
  input wire logic cyclicFault,
  input wire logic calDone,
  input wire positioner_mode_pkg::setpoint_type linkSetpoint,
  input wire positioner_mode_pkg::setpoint_type adcSetpoint,
  input wire positioner_mode_pkg::mode_type mode,
  input wire positioner_mode_pkg::lamps_type lamps,
  input wire logic menuEnable,
  input wire logic calStroke,
  input wire logic diagRun,
  input wire logic [1:0] fallbackAct
);
  import positioner_mode_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ----
  // properties
  // ----
  property p_fault_lamps;
    $past(mode) == MODE_FAULT && mode == MODE_FAULT |-> lamps == 5'h10 && !menuEnable;
  endproperty
  a_fault_lamps: assert property (p_fault_lamps)
    else $error("fault indication wrong");
  property p_fault_hold;
    mode == MODE_FAULT |=> mode == MODE_FAULT || mode == MODE_INIT;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault state left without reset");
  property p_cyclic_fault;
    cyclicFault && mode inside {MODE_OUT_OF_SERVICE, MODE_OPERATE, MODE_SETPOINT_LOSS}
      |-> ##[1:3] mode == MODE_FAULT;
  endproperty
  a_cyclic_fault: assert property (p_cyclic_fault)
    else $error("cyclic fault not taken");
  property p_loss_resume;
    mode == MODE_SETPOINT_LOSS && linkSetpoint.valid && adcSetpoint.valid && !cyclicFault
      |=> mode == MODE_OPERATE;
  endproperty
  a_loss_resume: assert property (p_loss_resume)
    else $error("no prompt return to operation");
  property p_loss_action;
    mode != MODE_SETPOINT_LOSS && $past(mode) != MODE_SETPOINT_LOSS |-> fallbackAct == 2'h0;
  endproperty
  a_loss_action: assert property (p_loss_action)
    else $error("fallback action outside loss");
  property p_loss_diag;
    mode == MODE_SETPOINT_LOSS [*2] |-> diagRun;
  endproperty
  a_loss_diag: assert property (p_loss_diag)
    else $error("diagnosis stopped in loss");
  property p_cal_stroke;
    mode == MODE_CALIBRATE [*2] |-> calStroke;
  endproperty
  a_cal_stroke: assert property (p_cal_stroke)
    else $error("no stroking in calibration");
  property p_cal_done;
    mode == MODE_CALIBRATE && calDone && !cyclicFault |-> ##[1:2] mode == MODE_OPERATE;
  endproperty
  a_cal_done: assert property (p_cal_done)
    else $error("calibration end not followed by operation");
  property p_oos_menu;
    $past(mode) == MODE_OUT_OF_SERVICE && mode == MODE_OUT_OF_SERVICE |-> menuEnable;
  endproperty
  a_oos_menu: assert property (p_oos_menu)
    else $error("menu blocked out of service");
  c_fault: cover property (mode == MODE_FAULT);
  c_loss: cover property ($rose(mode == MODE_SETPOINT_LOSS));
  c_cal: cover property (mode == MODE_CALIBRATE ##1 mode == MODE_OPERATE);
endmodule // positioner_mode_checker

bind positioner_mode_sequencer positioner_mode_checker u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .cyclicFault(cyclicFault), .calDone(calDone),
  .linkSetpoint(linkSetpoint), .adcSetpoint(adcSetpoint), .mode(mode), .lamps(lamps),
  .menuEnable(menuEnable),
  .calStroke(calStroke), .diagRun(diagRun), .fallbackAct(fallbackAct)
);

// file: setpoint_link_source.sv
// control system model sending demodulated setpoints over the link
// assumes the sequencer clock; pulses once every period+1 cycles while enabled
`timescale 1ns/1ps
module setpoint_link_source (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // control
  input wire logic sendEn,
  input wire logic [7:0] period,
  // link
  output positioner_mode_pkg::setpoint_type linkOut
);
  import positioner_mode_pkg::*;
  logic [7:0] cnt_ff;
  logic [15:0] seq_ff;
  setpoint_type link_ff;
  assign linkOut = link_ff;
  // idle value toggles every cycle so a stale setpoint cannot look valid
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 8'h00;
      seq_ff <= 16'h1234;
      link_ff <= '0;
    end else if (sendEn && cnt_ff == 8'h00) begin
      cnt_ff <= period;
      seq_ff <= seq_ff + 16'h3C5B;
      link_ff <= '{valid: 1'b1, value: seq_ff};
    end else begin
      cnt_ff <= (cnt_ff == 8'h00) ? 8'h00 : cnt_ff - 8'h01;
      link_ff <= '{valid: 1'b0, value: ~link_ff.value};
    end
  end
endmodule // setpoint_link_source

// file: tb_top.sv
// self-checking bench for the positioner operating-mode sequencer
// assumes the link source model and the property checker are compiled first
`timescale 1ns/1ps
module tb_top;
  import positioner_mode_pkg::*;
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic keyUp, keyDown, keyMenu, testFail, cyclicFault, calDone, calNvIn, sendEn;
  logic menuEnable, calStroke, calNvOut, diagRun, selAnalog;
  logic clkEn, calNvInValid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, testCode;
  logic [1:0] fallbackAct;
  logic [15:0] expVal;
  setpoint_type linkSetpoint, adcSetpoint, ctrlSetpoint;
  mode_type mode;
  lamps_type lamps;
  int fails = 0;
  int checks = 0;
  int seed = 46;
  int spCount = 0;

  positioner_mode_sequencer #(.STEP_COUNT(4)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .keyUp(keyUp), .keyDown(keyDown),
    .keyMenu(keyMenu), .testFail(testFail), .cyclicFault(cyclicFault), .calDone(calDone),
    .calNvIn(calNvIn), .calNvInValid(calNvInValid), .linkSetpoint(linkSetpoint),
    .adcSetpoint(adcSetpoint), .mode(mode), .lamps(lamps), .testCode(testCode),
    .menuEnable(menuEnable), .calStroke(calStroke), .calNvOut(calNvOut),
    .diagRun(diagRun), .ctrlSetpoint(ctrlSetpoint), .fallbackAct(fallbackAct)
  );
  setpoint_link_source u_src (.sys_clk(sys_clk), .nrst(nrst), .sendEn(sendEn),
    .period(8'h04), .linkOut(linkSetpoint));

  // ----
  // tasks
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hF};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (n >= 16) fails++;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wait_mode(input mode_type m, input int lim);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (mode !== m && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    check(mode, m, "mode");
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask
  task automatic key_reset();
    @(posedge sys_clk);
    {keyUp, keyDown, keyMenu} <= 3'b111;
    repeat (4) @(posedge sys_clk);
    {keyUp, keyDown, keyMenu} <= 3'b000;
  endtask

  // ----
  // clock, setpoint model and watchdog
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    adcSetpoint <= '{valid: 1'($random(seed)), value: 16'($random(seed))};
    if (selAnalog ? adcSetpoint.valid : linkSetpoint.valid)
      expVal <= selAnalog ? adcSetpoint.value : linkSetpoint.value;
    if (nrst && ctrlSetpoint.valid === 1'b1) begin
      check(ctrlSetpoint.value, expVal, "sp");
      spCount++;
    end
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    fails++;
    final_report();
  end

  // ----
  // tests
  // ----
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= '0;
    {keyUp, keyDown, keyMenu, testFail, cyclicFault, calDone, calNvIn} <= '0;
    {sendEn, selAnalog} <= 2'b00;
    {clkEn, calNvInValid} <= 2'b11;
    do_reset();
    @(negedge sys_clk);
    check(mode, MODE_INIT, "init");
    @(posedge sys_clk);
    clkEn <= 1'b0;
    repeat (50) @(posedge sys_clk);
    check(mode, MODE_INIT, "frozen");
    clkEn <= 1'b1;
    wait_mode(MODE_OUT_OF_SERVICE, 60);
    check(menuEnable, 1, "menu");
    apb(0, STATUS_OFFSET, 0);
    check(rd[6:0], {1'b0, MODE_OUT_OF_SERVICE}, "status");
    apb(0, TIMEOUT_OFFSET, 0);
    check(rd, TIMEOUT_RESET, "limit");
    apb(0, 8'h10, 0);
    check(err, 1, "unmapped");
    $display("test boot done");
    apb(1, TIMEOUT_OFFSET, 32'h0000_000A);
    sendEn <= 1'b1;
    apb(1, CTRL_OFFSET, 32'h0000_0001);
    wait_mode(MODE_CALIBRATE, 4);
    repeat (20) @(negedge sys_clk);
    check(mode, MODE_CALIBRATE, "busy");
    check(calStroke, 1, "stroke");
    @(posedge sys_clk);
    calDone <= 1'b1;
    @(posedge sys_clk);
    calDone <= 1'b0;
    wait_mode(MODE_OPERATE, 4);
    @(negedge sys_clk);
    check(calNvOut, 1, "flag");
    repeat (40) @(negedge sys_clk);
    check(mode, MODE_OPERATE, "fed");
    check(spCount != 0, 1, "sp seen");
    $display("test calibrate done");
    for (int f = 0; f < 3; f++) begin
      apb(1, CTRL_OFFSET, 32'(f) << CTRL_FALLBACK_LSB);
      sendEn <= 1'b0;
      repeat (5) @(negedge sys_clk);
      check(mode, MODE_OPERATE, "early");
      wait_mode(MODE_SETPOINT_LOSS, 20);
      @(negedge sys_clk);
      check(fallbackAct, f, "action");
      check(diagRun, 1, "diag");
      @(posedge sys_clk);
      sendEn <= 1'b1;
      wait_mode(MODE_OPERATE, 3);
    end
    $display("test loss done");
    apb(1, CTRL_OFFSET, 32'h0000_0010);
    selAnalog <= 1'b1;
    repeat (30) @(posedge sys_clk);
    apb(1, CTRL_OFFSET, 32'h0000_0000);
    selAnalog <= 1'b0;
    calNvIn <= 1'b1;
    calNvInValid <= 1'b0;
    do_reset();
    repeat (50) @(negedge sys_clk);
    check(mode, MODE_INIT, "unloaded");
    @(posedge sys_clk);
    calNvInValid <= 1'b1;
    wait_mode(MODE_OPERATE, 60);
    apb(1, CTRL_OFFSET, 32'h0000_0002);
    wait_mode(MODE_OUT_OF_SERVICE, 4);
    @(negedge sys_clk);
    check(calNvOut, 0, "cleared");
    $display("test restart done");
    calNvIn <= 1'b0;
    testFail <= 1'b1;
    key_reset();
    wait_mode(MODE_INIT, 8);
    repeat (40) @(negedge sys_clk);
    check(mode, MODE_INIT, "halt");
    check(testCode, 1, "code");
    @(posedge sys_clk);
    testFail <= 1'b0;
    key_reset();
    wait_mode(MODE_OUT_OF_SERVICE, 60);
    @(posedge sys_clk);
    cyclicFault <= 1'b1;
    wait_mode(MODE_FAULT, 4);
    @(negedge sys_clk);
    check(lamps, 5'h10, "lamps");
    check(menuEnable, 0, "locked");
    @(posedge sys_clk);
    cyclicFault <= 1'b0;
    apb(1, CTRL_OFFSET, 32'h0000_0005);
    repeat (6) @(negedge sys_clk);
    check(mode, MODE_FAULT, "latched");
    key_reset();
    wait_mode(MODE_INIT, 8);
    $display("test fault done");
    final_report();
  end
endmodule // tb_top
